/* rtl/irm_mode_ctrl.sv */
// Purpose: host-side controller that sets the transceiver speed mode
// Assumes: shutdown/mode, transmit and mode pins wired directly to the part
// Notes:   mode pin output enable is active low; high means pin floats
//
// Summary of operation
// R01: no mode known until a sequence or pin
// R02: static pin low slow, high fast
// R03: float mode pin when unused or standby
// R04: slow mode only up to 115.2 kbit/s
// R05: fast mode receives slow data, less sensitive
// R06: only the latch sequence switches latched mode
// R07: shutdown high, then transmit level, wait setup
// R08: falling shutdown edge captures transmit level
// R09: hold transmit level at least 200 ns after edge
// R10: after sequence transmit pin carries user data
// R11: transmit low across edge selects slow mode
// R12: receiver ignored while shutdown is high
// R13: latched mode kept until next falling edge
`timescale 1ns/1ps
`default_nettype none
module irm_mode_ctrl (
  input  wire logic CLK_IN,
  input  wire logic RST_IN,
  input  wire logic SET_REQ_IN,
  input  wire logic SET_HIGH_BW_IN,
  input  wire logic STANDBY_IN,
  input  wire logic STATIC_EN_IN,
  input  wire logic STATIC_HIGH_BW_IN,
  input  wire logic TX_DATA_IN,
  input  wire logic RXD_IN,
  output logic      SHUTDOWN_MODE_OUT,
  output logic      TXD_OUT,
  output logic      MODE_PIN_OUT,
  output logic      MODE_PIN_OE_N_OUT,
  output logic      RX_DATA_OUT,
  output logic      BUSY_OUT,
  output logic      DONE_OUT,
  output logic      MODE_VALID_OUT,
  output logic      MODE_HIGH_BW_OUT
);
  irm_pkg::irm_state_t state_reg;
  irm_pkg::irm_state_t state_next;
  logic sd_reg;
  logic sd_next;
  logic txd_reg;
  logic txd_next;
  logic target_reg;
  logic target_next;
  logic latched_hi_reg;
  logic latched_hi_next;
  logic latched_ok_reg;
  logic latched_ok_next;
  logic pin_reg;
  logic pin_next;
  logic pin_oe_n_reg;
  logic pin_oe_n_next;
  logic rx_reg;
  logic rx_next;
  logic done_reg;
  logic done_next;
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic timer_start;
  logic [irm_pkg::CNT_W-1:0] timer_load;
  logic timer_expired;
  logic usable;

  // rxd comes from the transceiver pin: two flops before use
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rxd_meta_reg <= 1'b0;
      rxd_sync_reg <= 1'b0;
    end else begin
      rxd_meta_reg <= RXD_IN;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // a mode exists only after a latch sequence or with STATIC_EN_IN set, even while the pin floats in standby
  assign usable = latched_ok_reg | STATIC_EN_IN; // [R01]

  always_comb begin
    state_next      = state_reg;
    sd_next         = sd_reg;
    txd_next        = txd_reg;
    target_next     = target_reg;
    latched_hi_next = latched_hi_reg;
    latched_ok_next = latched_ok_reg;
    done_next       = 1'b0;
    unique case (state_reg)
      irm_pkg::ST_OFF: begin
        sd_next  = 1'b1;
        txd_next = 1'b0;
        if (SET_REQ_IN) begin
          target_next = SET_HIGH_BW_IN;
          state_next  = irm_pkg::ST_ARM; // [R06]
        end else if (!STANDBY_IN && latched_ok_reg) begin
          // any falling edge relatches, so wake-up replays the held mode
          target_next = latched_hi_reg; // [R13]
          state_next  = irm_pkg::ST_ARM;
        end else if (!STANDBY_IN && usable) begin
          sd_next    = 1'b0;
          state_next = irm_pkg::ST_RUN;
        end
      end
      irm_pkg::ST_RUN: begin
        sd_next  = 1'b0;
        txd_next = TX_DATA_IN; // [R10]
        if (SET_REQ_IN) begin
          target_next = SET_HIGH_BW_IN;
          sd_next     = 1'b1;
          txd_next    = 1'b0;
          state_next  = irm_pkg::ST_ARM; // [R06]
        end else if (STANDBY_IN || !usable) begin
          sd_next    = 1'b1;
          txd_next   = 1'b0;
          state_next = irm_pkg::ST_OFF;
        end
      end
      irm_pkg::ST_ARM: begin
        // shutdown settles high before the transmit level moves
        sd_next  = 1'b1;
        txd_next = 1'b0;
        if (timer_expired) begin
          txd_next   = target_reg; // [R07] [R11]
          state_next = irm_pkg::ST_SETUP;
        end
      end
      irm_pkg::ST_SETUP: begin
        sd_next  = 1'b1;
        txd_next = target_reg;
        if (timer_expired) begin
          // falling edge here: the part captures txd at this moment
          sd_next         = 1'b0; // [R08]
          latched_hi_next = target_reg; // [R13]
          latched_ok_next = 1'b1;
          state_next      = irm_pkg::ST_HOLD;
        end
      end
      irm_pkg::ST_HOLD: begin
        sd_next  = 1'b0;
        txd_next = target_reg; // [R09]
        if (timer_expired) begin
          // released at the minimum so the pulse stays far below its limit
          txd_next   = TX_DATA_IN;
          done_next  = 1'b1;
          state_next = irm_pkg::ST_RUN;
        end
      end
      default: begin
        sd_next    = 1'b1;
        txd_next   = 1'b0;
        state_next = irm_pkg::ST_OFF;
      end
    endcase
  end

  assign timer_start = (state_next != state_reg);
  assign timer_load  = (state_next == irm_pkg::ST_HOLD) ? irm_pkg::THOLD_LOAD
                                                        : irm_pkg::TSETUP_LOAD;

  irm_delay u_delay (
    .clk_in      (CLK_IN),
    .rst_in      (RST_IN),
    .start_in    (timer_start),
    .load_in     (timer_load),
    .expired_out (timer_expired)
  );

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg      <= irm_pkg::ST_OFF;
      sd_reg         <= 1'b1;
      txd_reg        <= 1'b0;
      target_reg     <= 1'b0;
      latched_hi_reg <= 1'b0;
      latched_ok_reg <= 1'b0;
      done_reg       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      sd_reg         <= sd_next;
      txd_reg        <= txd_next;
      target_reg     <= target_next;
      latched_hi_reg <= latched_hi_next;
      latched_ok_reg <= latched_ok_next;
      done_reg       <= done_next;
    end
  end

  // static mode pin and receive path
  always_comb begin
    pin_next      = STATIC_HIGH_BW_IN; // [R02]
    pin_oe_n_next = !(STATIC_EN_IN && !STANDBY_IN); // [R03]
    // receiver output is meaningless while the part is shut down
    rx_next       = sd_next ? 1'b0 : rxd_sync_reg; // [R12]
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_reg      <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      rx_reg       <= 1'b0;
    end else begin
      pin_reg      <= pin_next;
      pin_oe_n_reg <= pin_oe_n_next;
      rx_reg       <= rx_next;
    end
  end

  assign SHUTDOWN_MODE_OUT = sd_reg;
  assign TXD_OUT           = txd_reg;
  assign MODE_PIN_OUT      = pin_reg;
  assign MODE_PIN_OE_N_OUT = pin_oe_n_reg;
  assign RX_DATA_OUT       = rx_reg;
  assign BUSY_OUT          = (state_reg == irm_pkg::ST_ARM) ||
                             (state_reg == irm_pkg::ST_SETUP) ||
                             (state_reg == irm_pkg::ST_HOLD);
  assign DONE_OUT          = done_reg;
  assign MODE_VALID_OUT    = usable;
  // high means fast range; slow range tops out at 115.2 kbit/s
  assign MODE_HIGH_BW_OUT  = STATIC_EN_IN ? STATIC_HIGH_BW_IN : latched_hi_reg; // [R04] [R05]

  // cycles spent in the current state, for the timing checks
  logic [irm_pkg::CNT_W-1:0] dwell_reg;
  logic [irm_pkg::CNT_W-1:0] dwell_next;
  always_comb begin
    dwell_next = dwell_reg;
    if (timer_start) begin
      dwell_next = irm_pkg::CNT_ZERO;
    end else if (dwell_reg != irm_pkg::CNT_MAX) begin
      dwell_next = dwell_reg + irm_pkg::CNT_ONE;
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      dwell_reg <= irm_pkg::CNT_ZERO;
    end else begin
      dwell_reg <= dwell_next;
    end
  end

  a_mode_unknown_reset: assert property (@(posedge CLK_IN) // [R01]
    RST_IN ##1 (!RST_IN && !STATIC_EN_IN) |-> !MODE_VALID_OUT)
    else $error("mode valid right after reset");
  a_setup_dwell: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R07]
    (state_reg == irm_pkg::ST_SETUP && state_next == irm_pkg::ST_HOLD)
      |-> (dwell_reg == irm_pkg::TSETUP_LOAD) && sd_reg && txd_reg == target_reg)
    else $error("setup interval wrong");
  a_latch_edge_txd: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R08]
    $fell(sd_reg) && $past(state_reg) == irm_pkg::ST_SETUP
      |-> txd_reg == $past(txd_reg) && txd_reg == MODE_HIGH_BW_OUT || STATIC_EN_IN)
    else $error("txd moved at latch edge");
  a_hold_min_time: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R09]
    (state_reg == irm_pkg::ST_SETUP && state_next == irm_pkg::ST_HOLD)
      |=> (txd_reg == target_reg && !sd_reg)[*8])
    else $error("txd released early after latch");
  a_hold_dwell: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R09]
    (state_reg == irm_pkg::ST_HOLD && state_next == irm_pkg::ST_RUN)
      |-> dwell_reg == irm_pkg::THOLD_LOAD ##1 DONE_OUT)
    else $error("hold interval wrong");
  a_txd_passthru: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R10]
    (state_reg == irm_pkg::ST_RUN && $past(state_reg) == irm_pkg::ST_RUN && !$past(SET_REQ_IN)
      && !$past(STANDBY_IN) && !sd_reg) |-> TXD_OUT == $past(TX_DATA_IN))
    else $error("txd not carrying data");
  a_rx_gated: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R12]
    SHUTDOWN_MODE_OUT |-> !RX_DATA_OUT)
    else $error("rx passed while shut down");
  a_mode_retained: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R13]
    $changed(latched_hi_reg) |-> $fell(sd_reg))
    else $error("latched mode changed without edge");
  a_seq_bounded: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R06]
    (state_reg == irm_pkg::ST_ARM && $past(state_reg) != irm_pkg::ST_ARM)
      |-> ##[50:80] DONE_OUT)
    else $error("sequence did not finish");
  a_static_pin: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R02]
    !$past(RST_IN) && $past(STATIC_EN_IN) && !$past(STANDBY_IN)
      |-> !MODE_PIN_OE_N_OUT && MODE_PIN_OUT == $past(STATIC_HIGH_BW_IN))
    else $error("static pin not driven");
  a_float_unused: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R03]
    (!$past(STATIC_EN_IN) || $past(STANDBY_IN)) |-> MODE_PIN_OE_N_OUT)
    else $error("mode pin driven when unused");

  c_high_bw_seq: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    DONE_OUT && MODE_HIGH_BW_OUT && !STATIC_EN_IN);
  c_low_bw_seq: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    DONE_OUT && !MODE_HIGH_BW_OUT && !STATIC_EN_IN);
  c_standby_resume: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg == irm_pkg::ST_OFF && MODE_VALID_OUT ##1 state_reg == irm_pkg::ST_ARM);
  c_static_mode: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    !MODE_PIN_OE_N_OUT && MODE_PIN_OUT);
endmodule
`default_nettype wire

/* rtl/irm_pkg.sv */
// Purpose: shared constants and types for the infrared speed-mode controller
// Assumes: 100 MHz system clock
// Notes:   timing counts are derived from the printed nanosecond figures
package irm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TSETUP_NS     = 200;
  localparam int unsigned THOLD_NS      = 200;
  localparam int unsigned CNT_W         = 8;

  // least times round up to whole cycles, never below one
  function automatic int unsigned min_cycles(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned TSETUP_CYC = min_cycles(TSETUP_NS);
  localparam int unsigned THOLD_CYC  = min_cycles(THOLD_NS);
  localparam logic [CNT_W-1:0] TSETUP_LOAD = CNT_W'(TSETUP_CYC - 1);
  localparam logic [CNT_W-1:0] THOLD_LOAD  = CNT_W'(THOLD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE     = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX     = 8'hFF;

  typedef enum logic [2:0] {
    ST_OFF   = 3'h0,
    ST_RUN   = 3'h1,
    ST_ARM   = 3'h2,
    ST_SETUP = 3'h3,
    ST_HOLD  = 3'h4
  } irm_state_t;
endpackage

/* rtl/irm_delay.sv */
// Purpose: down-counter giving minimum dwell times for the mode sequence
// Assumes: start is a one-cycle pulse in the cycle before the timed interval
// Notes:   expired is high once load_in+1 cycles have passed since start
`timescale 1ns/1ps
`default_nettype none
module irm_delay (
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      start_in,
  input  wire logic [irm_pkg::CNT_W-1:0] load_in,
  output logic                           expired_out
);
  logic [irm_pkg::CNT_W-1:0] count_reg;
  logic [irm_pkg::CNT_W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (start_in) begin
      count_next = load_in;
    end else if (count_reg != irm_pkg::CNT_ZERO) begin
      count_next = count_reg - irm_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_reg <= irm_pkg::CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  assign expired_out = (count_reg == irm_pkg::CNT_ZERO);
endmodule
`default_nettype wire

/* tb/irm_xcvr_model.sv */
// Purpose: behavioural transceiver speed-mode latch facing the controller
// Assumes: pins wired straight from the controller, no board delay
// Notes:   flags setup or hold under 200 ns around the latching edge
`timescale 1ns/1ps
`default_nettype none
module irm_xcvr_model (
  input  wire logic sd_in,
  input  wire logic txd_in,
  input  wire logic pin_in,
  input  wire logic pin_oe_n_in,
  input  wire logic rx_src_in,
  output logic      rxd_out,
  output logic      lat_valid_out,
  output logic      lat_hbw_out,
  output logic      eff_hbw_out,
  output logic      tim_err_out
);
  realtime t_tx   = 0.0;
  realtime t_fall = -1000.0;
  initial begin
    lat_valid_out = 1'b0;
    lat_hbw_out   = 1'b0;
    tim_err_out   = 1'b0;
  end
  always @(txd_in) begin
    if ($realtime - t_fall < 200.0) tim_err_out = 1'b1;
    t_tx = $realtime;
  end
  // every falling edge relatches, so leaving shutdown with txd low means slow
  always @(negedge sd_in) begin
    if ($realtime - t_tx < 200.0) tim_err_out = 1'b1;
    lat_valid_out = 1'b1;
    lat_hbw_out   = txd_in;
    t_fall        = $realtime;
  end
  // a driven mode pin overrides the latch; slow data still lands in fast mode
  assign eff_hbw_out = !pin_oe_n_in ? pin_in : lat_hbw_out;
  // receiver output grounded while shut down
  assign rxd_out = sd_in ? 1'b0 : rx_src_in;
endmodule
`default_nettype wire

/* tb/irm_mode_ctrl_tb_top.sv */
// Purpose: self-checking bench for the speed-mode controller
// Assumes: inputs driven at the falling clock edge
// Notes:   sequence latency taken from the hand-over walk
`timescale 1ns/1ps
`default_nettype none
module irm_mode_ctrl_tb_top;
  logic clk, rst, set_req, set_hbw, standby, st_en, st_hbw, tx_data, rx_src;
  logic sd, txd, pin, pin_oe_n, rxd, rx_data, busy, done, m_valid, m_hbw;
  logic l_valid, l_hbw, e_hbw, t_err;
  int   err_total = 0;
  int   tests_run = 0;

  irm_mode_ctrl dut_u (.CLK_IN(clk), .RST_IN(rst), .SET_REQ_IN(set_req),
    .SET_HIGH_BW_IN(set_hbw), .STANDBY_IN(standby), .STATIC_EN_IN(st_en),
    .STATIC_HIGH_BW_IN(st_hbw), .TX_DATA_IN(tx_data), .RXD_IN(rxd),
    .SHUTDOWN_MODE_OUT(sd), .TXD_OUT(txd), .MODE_PIN_OUT(pin),
    .MODE_PIN_OE_N_OUT(pin_oe_n), .RX_DATA_OUT(rx_data), .BUSY_OUT(busy),
    .DONE_OUT(done), .MODE_VALID_OUT(m_valid), .MODE_HIGH_BW_OUT(m_hbw));
  irm_xcvr_model xcvr_u (.sd_in(sd), .txd_in(txd), .pin_in(pin),
    .pin_oe_n_in(pin_oe_n), .rx_src_in(rx_src), .rxd_out(rxd),
    .lat_valid_out(l_valid), .lat_hbw_out(l_hbw), .eff_hbw_out(e_hbw),
    .tim_err_out(t_err));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic seen, input logic exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // poke fires a request mid-sequence that must be ignored
  task automatic seq(input logic hbw, input bit poke);
    int n;
    set_req = 1'b1;
    set_hbw = hbw;
    @(negedge clk);
    set_req = 1'b0;
    chk(busy, 1'b1, "busy after request");
    chk(sd, 1'b1, "shutdown raised first");
    n = 1;
    while (done !== 1'b1 && n < 100) begin
      if (poke && n == 5) begin
        set_req = 1'b1;
        set_hbw = ~hbw;
      end
      if (poke && n == 6) begin
        set_req = 1'b0;
        set_hbw = hbw;
      end
      if (n == 21) chk(txd, hbw, "txd level before edge");
      if (n == 30) chk(rx_data, 1'b0, "rx gated in shutdown");
      if (n == 40) chk(sd, 1'b1, "shutdown held over setup");
      if (n == 41) chk(sd, 1'b0, "shutdown falls");
      @(negedge clk);
      n++;
    end
    chk(n == 61, 1'b1, "done latency");
    chk(m_valid, 1'b1, "mode valid");
    chk(m_hbw, hbw, "reported mode");
    chk(l_hbw, hbw, "latched mode at part");
    chk(t_err, 1'b0, "setup or hold too short");
  endtask

  task automatic tx_pass;
    tx_data = 1'b1;
    @(negedge clk);
    chk(txd, 1'b1, "txd carries data");
    repeat (3) @(negedge clk);
    chk(rx_data, 1'b1, "rx passes when active");
    tx_data = 1'b0;
    @(negedge clk);
    chk(txd, 1'b0, "txd follows data low");
  endtask

  task automatic static_pin;
    st_en  = 1'b1;
    st_hbw = 1'b0;
    @(negedge clk);
    chk(pin_oe_n, 1'b0, "pin driven");
    chk(m_hbw, 1'b0, "static low slow");
    chk(e_hbw, 1'b0, "part sees slow");
    st_hbw = 1'b1;
    @(negedge clk);
    chk(pin, 1'b1, "static pin high");
    chk(e_hbw, 1'b1, "part sees fast");
    st_en = 1'b0;
    @(negedge clk);
    chk(pin_oe_n, 1'b1, "pin floats unused");
    chk(m_hbw, 1'b1, "latched mode back");
  endtask

  task automatic standby_chk(input logic hbw);
    int n;
    standby = 1'b1;
    @(negedge clk);
    chk(sd, 1'b1, "standby shuts part");
    chk(txd, 1'b0, "txd low in standby");
    chk(pin_oe_n, 1'b1, "pin floats in standby");
    chk(rx_data, 1'b0, "rx gated in standby");
    repeat (3) @(negedge clk);
    chk(m_valid, 1'b1, "mode kept in standby");
    standby = 1'b0;
    @(negedge clk);
    chk(sd, 1'b1, "wake replays latch first");
    chk(busy, 1'b1, "wake sequence running");
    n = 1;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n == 61, 1'b1, "wake sequence latency");
    chk(sd, 1'b0, "standby released");
    chk(l_hbw, hbw, "part keeps mode");
    chk(m_hbw, hbw, "reported mode kept");
    chk(t_err, 1'b0, "release timing");
  endtask

  initial begin
    rst = 1'b1;
    set_req = 1'b0;
    set_hbw = 1'b0;
    standby = 1'b0;
    st_en = 1'b0;
    st_hbw = 1'b0;
    tx_data = 1'b0;
    rx_src = 1'b1;
    repeat (10) @(negedge clk);
    chk(sd, 1'b1, "reset shutdown");
    chk(txd, 1'b0, "reset txd");
    chk(pin_oe_n, 1'b1, "reset pin floats");
    chk(m_valid, 1'b0, "no mode at reset");
    chk(l_valid, 1'b0, "part has no mode");
    chk(busy, 1'b0, "reset idle");
    rst = 1'b0;
    @(negedge clk);
    seq(1'b1, 1'b0);
    seq(1'b0, 1'b1);
    seq(1'b1, 1'b0);
    tx_pass();
    static_pin();
    seq(1'b0, 1'b0);
    standby_chk(1'b0);
    seq(1'b1, 1'b0);
    standby_chk(1'b1);
    conclude();
  end

  initial begin
    #20us;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
